// ### bench/nmi_source_aggregation_bench.sv
// Self-checking bench for the NMI source aggregation block
`timescale 1ns/1ps
`include "nsa_defs.vh"
module nmi_source_aggregation_bench;
  reg CLK_SYS_IN = 1'b0, ARST_N_IN = 1'b0, cs = 1'b0, WB_WE_IN = 1'b0;
  reg TIMER2_EVENT_IN = 1'b0, OSC_TOO_LOW_IN = 1'b0;
  reg [7:0] WB_ADR_IN = 8'h0;
  reg [31:0] WB_DAT_IN = 32'h0, q;
  reg [3:0] ot = 4'h0, uv = 4'h0, ov = 4'h0;
  reg [2:0] ext = 3'h0;
  reg [1:0] clkf = 2'h0, ecc = 2'h0;
  wire [31:0] WB_DAT_OUT;
  wire WB_ACK_OUT, NMI_REQ_OUT, TIMER2_NODE0_REQ_OUT, IRQ_OUT;
  wire [7:0] irq_cnt;
  int err_total = 0, n_tests = 0;
  nsa_top nsa_top_i (.CLK_SYS_IN, .ARST_N_IN, .CLK_EN_IN(1'b1), .WB_CYC_IN(cs), .WB_STB_IN(cs),
    .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN(4'hf), .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT,
    .SYSTEM_OVERTEMP_WARNING_IN(ot[0]), .SYSTEM_OVERTEMP_IN(ot[1]),
    .POWER_UNIT_OVERTEMP_WARNING_IN(ot[2]), .POWER_UNIT_OVERTEMP_IN(ot[3]),
    .SUPPLY_UNDERVOLTAGE_IN(uv), .SUPPLY_OVERVOLTAGE_IN(ov), .EXT_SUPPLY_OVERVOLT_IN(ext[0]),
    .EXT_SUPPLY_OVERLOAD_IN(ext[1]), .EXT_SUPPLY_SHORT_IN(ext[2]),
    .MEAS_IFACE_CLOCK_FAIL_IN(clkf[0]), .FILTER_CLOCK_FAIL_IN(clkf[1]), .OSC_TOO_LOW_IN,
    .RAM_DOUBLE_BIT_ERROR_IN(ecc[0]), .NVM_DOUBLE_BIT_ERROR_IN(ecc[1]), .TIMER2_EVENT_IN,
    .NMI_REQ_OUT, .TIMER2_NODE0_REQ_OUT, .IRQ_OUT);
  nsa_core_model nsa_core_model_i (.clk(CLK_SYS_IN), .rst_n(ARST_N_IN), .nmi(NMI_REQ_OUT),
    .irq(IRQ_OUT), .nmi_cnt_q(), .irq_cnt_q(irq_cnt));
  initial forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS_IN);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cs <= 1'b1;
    WB_WE_IN <= we;
    WB_ADR_IN <= a;
    WB_DAT_IN <= d;
    do begin
      @(posedge CLK_SYS_IN);
      n++;
    end while (WB_ACK_OUT !== 1'b1 && n < 9);
    chk(WB_ACK_OUT, 32'h1);
    if (WB_ACK_OUT !== 1'b1) finish_test();
    q = WB_DAT_OUT;
    cs <= 1'b0;
    @(posedge CLK_SYS_IN);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic t_reset;
    for (int a = 0; a <= 'h30; a += 4) rd(a[7:0], 32'h0);
    wb(1'b1, 8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0);
  endtask
  task automatic t_edge;
    {ot, uv, ov} <= 12'hfff;
    tick(3);
    rd(`NSA_SYS_STS_ADDR, 32'hf);
    rd(`NSA_SUP_STS_ADDR, 32'hff);
    chk(NMI_REQ_OUT, 32'h0);
    wb(1'b1, `NSA_SYS_STS_ADDR, 32'hf);
    wb(1'b1, `NSA_SUP_STS_ADDR, 32'hff);
    rd(`NSA_SYS_STS_ADDR, 32'h0);
    rd(`NSA_SUP_STS_ADDR, 32'h0);
    rd(`NSA_NMI_STS_ADDR, 32'h2);
    wb(1'b1, `NSA_NMI_STS_ADDR, 32'h2);
    rd(`NSA_NMI_STS_ADDR, 32'h0);
    {ot, uv, ov} <= 12'h0;
    wb(1'b1, `NSA_SYS_EN_ADDR, 32'h8);
    ot <= 4'h8;
    tick(4);
    chk(NMI_REQ_OUT, 32'h1);
    wb(1'b1, `NSA_SYS_STS_ADDR, 32'h8);
    tick(2);
    chk(NMI_REQ_OUT, 32'h0);
    wb(1'b1, `NSA_SYS_EN_ADDR, 32'h0);
  endtask
  task automatic t_level;
    wb(1'b1, `NSA_EXT_STS_ADDR, 32'h100);
    wb(1'b1, `NSA_ECC_EN_ADDR, 32'h2);
    {ext, ecc} <= 5'h13;
    tick(2);
    ecc <= 2'h0;
    wb(1'b1, `NSA_EXT_STS_ADDR, 32'h107);
    rd(`NSA_EXT_STS_ADDR, 32'h104);
    chk(NMI_REQ_OUT, 32'h1);
    ext <= 3'h0;
    rd(`NSA_ECC_STS_ADDR, 32'h3);
    wb(1'b1, `NSA_EXT_STS_ADDR, 32'h7);
    tick(2);
    chk(NMI_REQ_OUT, 32'h1);
    wb(1'b1, `NSA_ECC_STS_ADDR, 32'h2);
    tick(2);
    chk(NMI_REQ_OUT, 32'h0);
    wb(1'b1, `NSA_ECC_STS_ADDR, 32'h1);
  endtask
  task automatic t_clk;
    clkf <= 2'h1;
    tick(2);
    clkf <= 2'h0;
    rd(`NSA_CLK_STS_ADDR, 32'h1);
    rd(`NSA_NMI_STS_ADDR, 32'h0);
    wb(1'b1, `NSA_CLK_STS_ADDR, 32'h103);
    wb(1'b1, `NSA_NMI_EN_ADDR, 32'h1);
    clkf <= 2'h2;
    tick(2);
    clkf <= 2'h0;
    rd(`NSA_CLK_STS_ADDR, 32'h102);
    rd(`NSA_NMI_STS_ADDR, 32'h1);
    wb(1'b1, `NSA_CLK_STS_ADDR, 32'h2);
    OSC_TOO_LOW_IN <= 1'b1;
    wb(1'b1, `NSA_NMI_STS_ADDR, 32'h1);
    rd(`NSA_CLK_STS_ADDR, 32'h4);
    chk(NMI_REQ_OUT, 32'h1);
    OSC_TOO_LOW_IN <= 1'b0;
    wb(1'b1, `NSA_NMI_STS_ADDR, 32'h1);
    tick(2);
    chk(NMI_REQ_OUT, 32'h0);
  endtask
  task automatic t_rst2;
    wb(1'b1, `NSA_ECC_EN_ADDR, 32'h1);
    ecc <= 2'h1;
    tick(3);
    ecc <= 2'h0;
    chk(NMI_REQ_OUT, 32'h1);
    ARST_N_IN <= 1'b0;
    tick(2);
    chk(NMI_REQ_OUT, 32'h0);
    ARST_N_IN <= 1'b1;
    tick(1);
    rd(`NSA_ECC_STS_ADDR, 32'h0);
    rd(`NSA_ECC_EN_ADDR, 32'h0);
  endtask
  task automatic t_t2(input logic en, input logic [7:0] cnt);
    wb(1'b1, `NSA_TMR_EN_ADDR, {31'h0, en});
    TIMER2_EVENT_IN <= 1'b1;
    tick(4);
    TIMER2_EVENT_IN <= 1'b0;
    chk(irq_cnt, cnt);
    wb(1'b1, `NSA_TMR_STS_ADDR, 32'h1);
  endtask
  initial begin
    tick(4);
    ARST_N_IN <= 1'b1;
    tick(1);
    t_reset();
    t_edge();
    t_level();
    t_clk();
    t_rst2();
    t_t2(1'b1, 8'h1);
    t_t2(1'b0, 8'h1);
    finish_test();
  end
endmodule

// ### bench/nsa_checker.sv
// Port assertions for the NMI source aggregation block
`timescale 1ns/1ps
module nsa_checker (
  input wire CLK_SYS_IN,
  input wire ARST_N_IN,
  input wire CLK_EN_IN,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [31:0] WB_DAT_OUT,
  input wire WB_ACK_OUT,
  input wire TIMER2_EVENT_IN,
  input wire NMI_REQ_OUT,
  input wire TIMER2_NODE0_REQ_OUT,
  input wire IRQ_OUT
);
  wire req = WB_CYC_IN && WB_STB_IN;
  wire ack = WB_ACK_OUT;
  wire t2 = TIMER2_NODE0_REQ_OUT;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_ack_req; req && !ack && CLK_EN_IN |=> ack; endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acked");
  property p_ack_once; ack && CLK_EN_IN |=> !ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_idle; !req && CLK_EN_IN |=> !ack; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_dat_hold; $changed(WB_DAT_OUT) |-> ack && !WB_WE_IN; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_t2_len; $rose(t2) |=> t2 ##1 !t2; endproperty
  a_t2_len: assert property (p_t2_len) else $error("timer pulse not two cycles");
  property p_t2_src; $rose(t2) |-> $past(TIMER2_EVENT_IN) && !$past(TIMER2_EVENT_IN, 2); endproperty
  a_t2_src: assert property (p_t2_src) else $error("timer pulse without event");
  property p_irq; $rose(t2) |-> IRQ_OUT; endproperty
  a_irq: assert property (p_irq) else $error("node 0 request mismatch");
  property p_nmi_fall; $fell(NMI_REQ_OUT) |-> $past(ack && WB_WE_IN); endproperty
  a_nmi_fall: assert property (p_nmi_fall) else $error("nmi dropped without write");
  c_write: cover property (ack && WB_WE_IN);
  c_nmi: cover property ($rose(NMI_REQ_OUT));
  c_t2: cover property ($rose(t2));
endmodule

bind nsa_top nsa_checker nsa_checker_i (.CLK_SYS_IN, .ARST_N_IN, .CLK_EN_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_WE_IN, .WB_DAT_OUT, .WB_ACK_OUT, .TIMER2_EVENT_IN, .NMI_REQ_OUT,
  .TIMER2_NODE0_REQ_OUT, .IRQ_OUT);

// ### bench/nsa_core_model.sv
// Core-side model: counts NMI entries and node 0 requests
`timescale 1ns/1ps
module nsa_core_model (
  input wire clk,
  input wire rst_n,
  input wire nmi,
  input wire irq,
  output reg [7:0] nmi_cnt_q,
  output reg [7:0] irq_cnt_q
);
  reg nmi_seen_q;
  reg irq_seen_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {nmi_cnt_q, irq_cnt_q, nmi_seen_q, irq_seen_q} <= '0;
    end else begin
      {nmi_seen_q, irq_seen_q} <= {nmi, irq};
      nmi_cnt_q <= nmi_cnt_q + {7'h0, nmi & ~nmi_seen_q};
      irq_cnt_q <= irq_cnt_q + {7'h0, irq & ~irq_seen_q};
    end
  end
endmodule

// ### core/nsa_defs.vh
// Register offsets, field positions and reset values of the NMI source aggregation block
`ifndef NSA_DEFS_VH
`define NSA_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define NSA_SYS_STS_ADDR 8'h00
`define NSA_SYS_EN_ADDR 8'h04
`define NSA_SUP_STS_ADDR 8'h08
`define NSA_SUP_EN_ADDR 8'h0c
`define NSA_EXT_STS_ADDR 8'h10
`define NSA_NMI_STS_ADDR 8'h14
`define NSA_NMI_EN_ADDR 8'h18
`define NSA_ECC_STS_ADDR 8'h1c
`define NSA_ECC_EN_ADDR 8'h20
`define NSA_TMR_STS_ADDR 8'h24
`define NSA_TMR_EN_ADDR 8'h28
`define NSA_CLK_STS_ADDR 8'h2c

// ****************************************
// Field positions
// ****************************************
`define NSA_SYSTEM_OVERTEMP_WARNING_BIT 0
`define NSA_SYSTEM_OVERTEMP_BIT 1
`define NSA_PU_OTWARN_BIT 2
`define NSA_PU_OT_BIT 3
`define NSA_EXT_OVERVOLT_BIT 0
`define NSA_EXT_OVERLOAD_BIT 1
`define NSA_EXT_SHORT_BIT 2
`define NSA_EXT_FAIL_EN_BIT 8
`define NSA_NMI_OSCWD_BIT 0
`define NSA_NMI_SUP_BIT 1
`define NSA_CLK_MEAS_BIT 0
`define NSA_CLK_FILT_BIT 1
`define NSA_CLK_OSC_LOW_BIT 2
`define NSA_CLK_WDT_IE_BIT 8
`define NSA_ECC_RAM_BIT 0
`define NSA_ECC_NVM_BIT 1
`define NSA_TMR_T2_BIT 0

// ****************************************
// Reset values and timing
// ****************************************
`define NSA_RESET_WORD 32'h0000_0000
`define NSA_T2_PULSE_CYC 2

`endif

// ### core/nsa_top.v
// NMI source aggregation with sticky flags, enables and Wishbone slave
`timescale 1ns/1ps
`include "nsa_defs.vh"

module nsa_top #(
  parameter T2_PULSE_CYC = `NSA_T2_PULSE_CYC
) (
  input wire CLK_SYS_IN,
  input wire ARST_N_IN,
  input wire CLK_EN_IN,
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output reg [31:0] WB_DAT_OUT,
  output reg WB_ACK_OUT,
  input wire SYSTEM_OVERTEMP_WARNING_IN,
  input wire SYSTEM_OVERTEMP_IN,
  input wire POWER_UNIT_OVERTEMP_WARNING_IN,
  input wire POWER_UNIT_OVERTEMP_IN,
  input wire [3:0] SUPPLY_UNDERVOLTAGE_IN,
  input wire [3:0] SUPPLY_OVERVOLTAGE_IN,
  input wire EXT_SUPPLY_OVERVOLT_IN,
  input wire EXT_SUPPLY_OVERLOAD_IN,
  input wire EXT_SUPPLY_SHORT_IN,
  input wire MEAS_IFACE_CLOCK_FAIL_IN,
  input wire FILTER_CLOCK_FAIL_IN,
  input wire OSC_TOO_LOW_IN,
  input wire RAM_DOUBLE_BIT_ERROR_IN,
  input wire NVM_DOUBLE_BIT_ERROR_IN,
  input wire TIMER2_EVENT_IN,
  output reg NMI_REQ_OUT,
  output reg TIMER2_NODE0_REQ_OUT,
  output wire IRQ_OUT
);

  // ****************************************
  // Helpers
  // ****************************************
  // Write-one-to-clear with hardware set priority
  function [7:0] wclr;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      wclr = (cur & ~clr) | set;
    end
  endfunction

  // Plain read-write register update
  function [7:0] wmask;
    input [7:0] cur;
    input [7:0] dat;
    input we;
    begin
      wmask = we ? dat : cur;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [3:0] sys_sts_q;
  reg [3:0] sys_en_q;
  reg [7:0] sup_sts_q;
  reg [7:0] sup_en_q;
  reg [2:0] ext_sts_q;
  reg ext_fail_en_q;
  reg [1:0] nmi_sts_q;
  reg [1:0] nmi_en_q;
  reg [1:0] clk_sts_q;
  reg clk_wdt_ie_q;
  reg [1:0] ecc_sts_q;
  reg [1:0] ecc_en_q;
  reg tmr_sts_q;
  reg tmr_en_q;
  // Edge detector history
  reg [3:0] ot_prev_q;
  reg [7:0] sup_prev_q;
  reg t2_prev_q;
  // Timer pulse counter
  reg [1:0] t2_cnt_q;

  // A request is taken only while ack is low, so each request gets one ack
  wire bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  wire wr_stb = bus_req & WB_WE_IN & WB_SEL_IN[0];
  wire wr_stb1 = bus_req & WB_WE_IN & WB_SEL_IN[1];
  wire [7:0] wd = WB_DAT_IN[7:0];

  function sel;
    input [7:0] adr;
    input [7:0] cmp;
    begin
      sel = (adr == cmp);
    end
  endfunction

  // ****************************************
  // Source sampling
  // ****************************************
  // Edge sources compare against last cycle's level
  wire [3:0] ot_now = {POWER_UNIT_OVERTEMP_IN, POWER_UNIT_OVERTEMP_WARNING_IN,
                       SYSTEM_OVERTEMP_IN, SYSTEM_OVERTEMP_WARNING_IN};
  wire [7:0] sup_now = {SUPPLY_OVERVOLTAGE_IN, SUPPLY_UNDERVOLTAGE_IN};
  wire [3:0] ot_rise = ot_now & ~ot_prev_q;
  wire [7:0] sup_rise = sup_now & ~sup_prev_q;
  // Level sources set their flags on every cycle the input is high
  wire [2:0] ext_now = {EXT_SUPPLY_SHORT_IN, EXT_SUPPLY_OVERLOAD_IN, EXT_SUPPLY_OVERVOLT_IN};
  wire [1:0] clk_now = {FILTER_CLOCK_FAIL_IN, MEAS_IFACE_CLOCK_FAIL_IN};
  wire [1:0] ecc_now = {NVM_DOUBLE_BIT_ERROR_IN, RAM_DOUBLE_BIT_ERROR_IN};
  wire t2_rise = TIMER2_EVENT_IN & ~t2_prev_q;
  wire sup_any = |sup_sts_q;
  // Clock fails enter the common watchdog flag only with their interrupt enable
  wire oscwd_set = ((|clk_now) & clk_wdt_ie_q) | OSC_TOO_LOW_IN;
  wire [1:0] nmi_set = {sup_any, oscwd_set};

  // Hardware set vectors, widened to the helper width
  wire [7:0] set_sys = {4'h0, ot_rise};
  wire [7:0] set_ext = {5'h0, ext_now};
  wire [7:0] set_clk = {6'h0, clk_now};
  wire [7:0] set_nmi = {6'h0, nmi_set};
  wire [7:0] set_ecc = {6'h0, ecc_now};

  // ****************************************
  // Register write decode
  // ****************************************
  // Flag and enable bytes need lane 0
  wire wr_sys_sts = wr_stb & sel(WB_ADR_IN, `NSA_SYS_STS_ADDR);
  wire wr_sys_en = wr_stb & sel(WB_ADR_IN, `NSA_SYS_EN_ADDR);
  wire wr_sup_sts = wr_stb & sel(WB_ADR_IN, `NSA_SUP_STS_ADDR);
  wire wr_sup_en = wr_stb & sel(WB_ADR_IN, `NSA_SUP_EN_ADDR);
  wire wr_ext_sts = wr_stb & sel(WB_ADR_IN, `NSA_EXT_STS_ADDR);
  wire wr_nmi_sts = wr_stb & sel(WB_ADR_IN, `NSA_NMI_STS_ADDR);
  wire wr_nmi_en = wr_stb & sel(WB_ADR_IN, `NSA_NMI_EN_ADDR);
  wire wr_clk_sts = wr_stb & sel(WB_ADR_IN, `NSA_CLK_STS_ADDR);
  wire wr_ecc_sts = wr_stb & sel(WB_ADR_IN, `NSA_ECC_STS_ADDR);
  wire wr_ecc_en = wr_stb & sel(WB_ADR_IN, `NSA_ECC_EN_ADDR);
  wire wr_tmr_sts = wr_stb & sel(WB_ADR_IN, `NSA_TMR_STS_ADDR);
  wire wr_tmr_en = wr_stb & sel(WB_ADR_IN, `NSA_TMR_EN_ADDR);
  // Bit 8 enables need lane 1
  wire wr_ext_hi = wr_stb1 & sel(WB_ADR_IN, `NSA_EXT_STS_ADDR);
  wire wr_clk_hi = wr_stb1 & sel(WB_ADR_IN, `NSA_CLK_STS_ADDR);

  // Write-one-to-clear masks
  wire [7:0] clr_sys = {4'h0, wd[3:0] & {4{wr_sys_sts}}};
  wire [7:0] clr_sup = wd & {8{wr_sup_sts}};
  wire [7:0] clr_ext = {5'h0, wd[2:0] & {3{wr_ext_sts}}};
  wire [7:0] clr_clk = {6'h0, wd[1:0] & {2{wr_clk_sts}}};
  wire [7:0] clr_nmi = {6'h0, wd[1:0] & {2{wr_nmi_sts}}};
  wire [7:0] clr_ecc = {6'h0, wd[1:0] & {2{wr_ecc_sts}}};
  wire clr_tmr = wd[`NSA_TMR_T2_BIT] & wr_tmr_sts;

  // ****************************************
  // Next values
  // ****************************************
  // Set wins over a same-cycle write-one clear
  wire [7:0] sys_sts_d = wclr({4'h0, sys_sts_q}, set_sys, clr_sys);
  wire [7:0] sup_sts_d = wclr(sup_sts_q, sup_rise, clr_sup);
  wire [7:0] ext_sts_d = wclr({5'h0, ext_sts_q}, set_ext, clr_ext);
  wire [7:0] clk_sts_d = wclr({6'h0, clk_sts_q}, set_clk, clr_clk);
  wire [7:0] nmi_sts_d = wclr({6'h0, nmi_sts_q}, set_nmi, clr_nmi);
  wire [7:0] ecc_sts_d = wclr({6'h0, ecc_sts_q}, set_ecc, clr_ecc);
  wire tmr_sts_d = t2_rise | (tmr_sts_q & ~clr_tmr);
  wire [7:0] sys_en_d = wmask({4'h0, sys_en_q}, wd, wr_sys_en);
  wire [7:0] sup_en_d = wmask(sup_en_q, wd, wr_sup_en);
  wire [7:0] nmi_en_d = wmask({6'h0, nmi_en_q}, wd, wr_nmi_en);
  wire [7:0] ecc_en_d = wmask({6'h0, ecc_en_q}, wd, wr_ecc_en);
  wire [7:0] tmr_en_d = wmask({7'h0, tmr_en_q}, wd, wr_tmr_en);
  wire ext_fail_en_d = wr_ext_hi ? WB_DAT_IN[`NSA_EXT_FAIL_EN_BIT] : ext_fail_en_q;
  wire clk_wdt_ie_d = wr_clk_hi ? WB_DAT_IN[`NSA_CLK_WDT_IE_BIT] : clk_wdt_ie_q;
  // Pulse length as a full word, narrowed to the counter on purpose
  wire [31:0] t2_len = T2_PULSE_CYC;
  wire t2_fire = t2_rise & tmr_en_q;

  // ****************************************
  // Edge history
  // ****************************************
  // Reset level matches the idle level of the pins, so no false edge
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ot_prev_q <= 4'h0;
      sup_prev_q <= 8'h00;
      t2_prev_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      ot_prev_q <= ot_now;
      sup_prev_q <= sup_now;
      t2_prev_q <= TIMER2_EVENT_IN;
    end
  end

  // ****************************************
  // Sticky status flags
  // ****************************************
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sys_sts_q <= 4'h0;
      sup_sts_q <= 8'h00;
      ext_sts_q <= 3'h0;
      clk_sts_q <= 2'h0;
      nmi_sts_q <= 2'h0;
      ecc_sts_q <= 2'h0;
      tmr_sts_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      sys_sts_q <= sys_sts_d[3:0];
      sup_sts_q <= sup_sts_d;
      ext_sts_q <= ext_sts_d[2:0];
      clk_sts_q <= clk_sts_d[1:0];
      nmi_sts_q <= nmi_sts_d[1:0];
      ecc_sts_q <= ecc_sts_d[1:0];
      tmr_sts_q <= tmr_sts_d;
    end
  end

  // ****************************************
  // Enables
  // ****************************************
  // Plain read-write; software clears the flags before setting these
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sys_en_q <= 4'h0;
      sup_en_q <= 8'h00;
      ext_fail_en_q <= 1'b0;
      nmi_en_q <= 2'h0;
      clk_wdt_ie_q <= 1'b0;
      ecc_en_q <= 2'h0;
      tmr_en_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      sys_en_q <= sys_en_d[3:0];
      sup_en_q <= sup_en_d;
      ext_fail_en_q <= ext_fail_en_d;
      nmi_en_q <= nmi_en_d[1:0];
      clk_wdt_ie_q <= clk_wdt_ie_d;
      ecc_en_q <= ecc_en_d[1:0];
      tmr_en_q <= tmr_en_d[0];
    end
  end

  // ****************************************
  // Timer pulse
  // ****************************************
  // Node 0 request held for the pulse length; the counter holds up to three
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      t2_cnt_q <= 2'h0;
    end else if (CLK_EN_IN) begin
      if (t2_fire)
        t2_cnt_q <= t2_len[1:0];
      else if (t2_cnt_q != 2'h0)
        t2_cnt_q <= t2_cnt_q - 2'h1;
    end
  end

  // ****************************************
  // NMI merge
  // ****************************************
  // Each source gated by its own enable before the merge; the three ext flags share ext_fail_en_q
  wire nmi_sys = |(sys_sts_q & sys_en_q);
  wire nmi_sup = |(sup_sts_q & sup_en_q);
  wire nmi_ext = (|ext_sts_q) & ext_fail_en_q;
  wire nmi_osc = nmi_sts_q[`NSA_NMI_OSCWD_BIT] & nmi_en_q[`NSA_NMI_OSCWD_BIT];
  wire nmi_pre = nmi_sts_q[`NSA_NMI_SUP_BIT] & nmi_en_q[`NSA_NMI_SUP_BIT];
  wire nmi_ecc = |(ecc_sts_q & ecc_en_q);
  wire nmi_d = nmi_sys | nmi_sup | nmi_ext | nmi_osc | nmi_pre | nmi_ecc;

  // ****************************************
  // Requests
  // ****************************************
  // Node 0 level request: pending timer flag with its enable
  assign IRQ_OUT = tmr_sts_q & tmr_en_q;

  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      NMI_REQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      NMI_REQ_OUT <= nmi_d;
    end
  end

  // Timer request covers the fire cycle and the counted tail
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      TIMER2_NODE0_REQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      TIMER2_NODE0_REQ_OUT <= t2_fire | (t2_cnt_q > 2'h1);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Composite words: flags low, enable at bit 8
  wire [31:0] ext_word = {23'h0, ext_fail_en_q, 5'h0, ext_sts_q};
  wire [31:0] clk_word = {23'h0, clk_wdt_ie_q, 5'h0, OSC_TOO_LOW_IN, clk_sts_q};

  reg [31:0] rd_d;
  always @* begin
    rd_d = `NSA_RESET_WORD;
    case (WB_ADR_IN)
      `NSA_SYS_STS_ADDR: rd_d = {28'h0, sys_sts_q};
      `NSA_SYS_EN_ADDR: rd_d = {28'h0, sys_en_q};
      `NSA_SUP_STS_ADDR: rd_d = {24'h0, sup_sts_q};
      `NSA_SUP_EN_ADDR: rd_d = {24'h0, sup_en_q};
      `NSA_EXT_STS_ADDR: rd_d = ext_word;
      `NSA_NMI_STS_ADDR: rd_d = {30'h0, nmi_sts_q};
      `NSA_NMI_EN_ADDR: rd_d = {30'h0, nmi_en_q};
      `NSA_ECC_STS_ADDR: rd_d = {30'h0, ecc_sts_q};
      `NSA_ECC_EN_ADDR: rd_d = {30'h0, ecc_en_q};
      `NSA_TMR_STS_ADDR: rd_d = {31'h0, tmr_sts_q};
      `NSA_TMR_EN_ADDR: rd_d = {31'h0, tmr_en_q};
      `NSA_CLK_STS_ADDR: rd_d = clk_word;
      default: rd_d = `NSA_RESET_WORD;
    endcase
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  // One ack per request; read data moves only on reads
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= `NSA_RESET_WORD;
    end else if (CLK_EN_IN) begin
      WB_ACK_OUT <= bus_req;
      if (bus_req && !WB_WE_IN)
        WB_DAT_OUT <= rd_d;
    end
  end

endmodule
